// file: src/i2cm_pkg.sv
// constants and types of the firmware-assisted i2c serial port
//
// Overview of operation
// - start-seen and stop-seen flags clear on reset and while the port is disabled
// - a detected start or stop updates the flags to show the latest condition
// - a pin whose direction bit selects output is driven low, latch ignored
// - event flag sets on start, stop and each byte (in slave mode only from a matching address on); interrupts when enabled
// - master use works in the slave-idle mode code or with slave active
// - interrupt enabled while bus busy fires at the next stop
// - after lost address arbitration the slave keeps receiving and acknowledges a matching write address
// - with clock-release bit clear the clock output is held low
// - the clock hold starts only after the line is sampled already low
// - the clock stays low until release bit set and all others released it
package i2cm_pkg;
    localparam logic [7:0] ADDR_GIC = 8'h0b;
    localparam logic [7:0] ADDR_PIF = 8'h0c;
    localparam logic [7:0] ADDR_BUF = 8'h13;
    localparam logic [7:0] ADDR_CON = 8'h14;
    localparam logic [7:0] ADDR_DIR = 8'h87;
    localparam logic [7:0] ADDR_PIEN = 8'h8c;
    localparam logic [7:0] ADDR_SADR = 8'h93;
    localparam logic [7:0] ADDR_STAT = 8'h94;
    localparam logic [7:0] ADDR_EVST = 8'h20;
    localparam logic [7:0] ADDR_EVCLR = 8'h21;
    localparam logic [7:0] ADDR_EVEN = 8'h22;
    localparam logic [7:0] RST_ZERO = 8'h00;
    localparam logic [7:0] RST_DIR = 8'hff;
    localparam int INT_GIE = 7;
    localparam int INT_PEIE = 6;
    localparam int FLG_EVT = 3;
    localparam int CON_OV = 6;
    localparam int CON_EN = 5;
    localparam int CON_REL = 4;
    localparam int ST_DA = 5;
    localparam int ST_P = 4;
    localparam int ST_S = 3;
    localparam int ST_RW = 2;
    localparam int ST_BF = 0;
    localparam int DIR_SCL = 6;
    localparam int DIR_SDA = 7;
    localparam int EV_START = 0;
    localparam int EV_STOP = 1;
    localparam int EV_BYTE = 2;
    localparam int EV_OV = 3;
    localparam logic [3:0] MODE_MIDLE = 4'hb;
    localparam logic [3:0] MODE_S7 = 4'h6;
    localparam logic [3:0] MODE_S7SP = 4'he;
    localparam logic [3:0] BIT_LAST = 4'h8;
    localparam logic [3:0] BIT_ACK = 4'h9;
    localparam logic [1:0] STAT_WMASK = 2'h3;

    typedef struct packed {
        logic [7:0] addr;
        logic [7:0] wdata;
        logic wr;
        logic rd;
    } i2cm_req_t;

    typedef struct packed {
        logic scl;
        logic sda;
    } i2cm_pins_t;
endpackage : i2cm_pkg

// file: src/i2cm_port.sv
// serial port with start/stop detection, byte framing, clock hold and register file
//
// Strobed register access is this design's own decision.
`timescale 1ns/1ps
`default_nettype none
module i2cm_port (
    input wire logic sys_clk,
    input wire logic arst_n,
    input wire i2cm_pkg::i2cm_req_t req,
    output logic [7:0] rd_data,
    input wire i2cm_pkg::i2cm_pins_t pin_in,
    output var i2cm_pkg::i2cm_pins_t pin_out,
    output var i2cm_pkg::i2cm_pins_t pin_oe,
    output logic irq
);
    import i2cm_pkg::*;

    logic [7:0] gic_r, pif_r, pien_r, buf_r, con_r, dir_r, sadr_r, stat_r;
    logic [3:0] evst_r, even_r;
    logic [1:0] scl_sy_r, sda_sy_r;
    logic scl_d_r, sda_d_r;
    logic [7:0] shift_r;
    logic [3:0] bitcnt_r;
    logic addr_ph_r, addressed_r, ack_r, hold_r;
    logic port_on, slave_on, scl_rise, scl_fall, start_det, stop_det;
    logic byte_done, addr_hit, take_byte;
    logic wr_buf_rd;
    logic [3:0] ev_set;

    function automatic logic hit(input i2cm_req_t r, input logic [7:0] a, input logic w);
        hit = (w ? r.wr : r.rd) && (r.addr == a);
    endfunction : hit

    // two-stage synchronisers, then a delayed copy for edge detection
    always_ff @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
            scl_sy_r <= 2'h3;
            sda_sy_r <= 2'h3;
            scl_d_r <= 1'b1;
            sda_d_r <= 1'b1;
        end else begin
            scl_sy_r <= {scl_sy_r[0], pin_in.scl};
            sda_sy_r <= {sda_sy_r[0], pin_in.sda};
            scl_d_r <= scl_sy_r[1];
            sda_d_r <= sda_sy_r[1];
        end
    end

    assign port_on = con_r[CON_EN];
    assign slave_on = (con_r[3:0] == MODE_S7) || (con_r[3:0] == MODE_S7SP);
    assign scl_rise = scl_sy_r[1] && !scl_d_r;
    assign scl_fall = !scl_sy_r[1] && scl_d_r;
    assign start_det = port_on && scl_sy_r[1] && scl_d_r && !sda_sy_r[1] && sda_d_r;
    assign stop_det = port_on && scl_sy_r[1] && scl_d_r && sda_sy_r[1] && !sda_d_r;
    assign byte_done = port_on && scl_fall && (bitcnt_r == BIT_ACK);
    assign addr_hit = addr_ph_r && (shift_r[7:1] == sadr_r[7:1]);
    assign take_byte = byte_done && (!slave_on || addressed_r || addr_hit);
    assign wr_buf_rd = hit(req, ADDR_BUF, 1'b0);
    assign ev_set = {take_byte && stat_r[ST_BF] && !wr_buf_rd, take_byte,
                     stop_det, start_det};

    // bit framing: eight data bits, then the acknowledge clock
    always_ff @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
            shift_r <= RST_ZERO;
            bitcnt_r <= 4'h0;
            addr_ph_r <= 1'b0;
            addressed_r <= 1'b0;
        end else if (!port_on || start_det || stop_det) begin
            bitcnt_r <= 4'h0;
            addr_ph_r <= start_det;
            addressed_r <= 1'b0;
        end else if (scl_rise && bitcnt_r < BIT_ACK) begin
            if (bitcnt_r < BIT_LAST) begin
                shift_r <= {shift_r[6:0], sda_sy_r[1]};
            end
            bitcnt_r <= bitcnt_r + 4'h1;
        end else if (byte_done) begin
            bitcnt_r <= 4'h0;
            addr_ph_r <= 1'b0;
            if (addr_ph_r && slave_on) begin
                addressed_r <= addr_hit;
            end
        end
    end

    // acknowledge drive during the ninth clock for a matched write address and for later bytes while addressed
    always_ff @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
            ack_r <= 1'b0;
        end else if (!port_on || !slave_on || byte_done || start_det || stop_det) begin
            ack_r <= 1'b0;
        end else if (scl_fall && bitcnt_r == BIT_LAST) begin
            ack_r <= addr_ph_r ? (addr_hit && !shift_r[0]) : addressed_r;
        end
    end

    // clock hold: begins only once the line is seen low, ends on release bit
    always_ff @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
            hold_r <= 1'b0;
        end else if (!port_on || con_r[CON_REL]) begin
            hold_r <= 1'b0;
        end else if (!scl_sy_r[1]) begin
            hold_r <= 1'b1;
        end
    end

    // open-drain pins: the level driven is always low
    always_ff @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
            pin_out <= '0;
            pin_oe <= '0;
        end else begin
            pin_out <= '0;
            pin_oe.scl <= !dir_r[DIR_SCL] || hold_r;
            pin_oe.sda <= !dir_r[DIR_SDA] || ack_r;
        end
    end

    // status: start/stop seen, data/address, direction, buffer full
    always_ff @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
            stat_r <= RST_ZERO;
        end else if (!port_on) begin
            stat_r[5:0] <= 6'h00;
            if (hit(req, ADDR_STAT, 1'b1)) begin
                stat_r[7:6] <= req.wdata[7:6] & STAT_WMASK;
            end
        end else begin
            if (hit(req, ADDR_STAT, 1'b1)) begin
                stat_r[7:6] <= req.wdata[7:6] & STAT_WMASK;
            end
            if (start_det) begin
                stat_r[ST_S] <= 1'b1;
                stat_r[ST_P] <= 1'b0;
            end else if (stop_det) begin
                stat_r[ST_P] <= 1'b1;
                stat_r[ST_S] <= 1'b0;
            end
            if (byte_done && addr_ph_r && slave_on && addr_hit) begin
                stat_r[ST_RW] <= shift_r[0];
            end
            if (take_byte) begin
                stat_r[ST_DA] <= !addr_ph_r;
                stat_r[ST_BF] <= 1'b1;
            end else if (wr_buf_rd) begin
                stat_r[ST_BF] <= 1'b0;
            end
        end
    end

    // receive buffer; a full buffer keeps its byte and flags overflow
    always_ff @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
            buf_r <= RST_ZERO;
        end else if (take_byte && (!stat_r[ST_BF] || wr_buf_rd)) begin
            buf_r <= shift_r;
        end else if (hit(req, ADDR_BUF, 1'b1)) begin
            buf_r <= req.wdata;
        end
    end

    // control register; hardware sets overflow and that wins over a write
    always_ff @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
            con_r <= RST_ZERO;
        end else begin
            if (hit(req, ADDR_CON, 1'b1)) begin
                con_r <= req.wdata;
            end
            if (ev_set[EV_OV]) begin
                con_r[CON_OV] <= 1'b1;
            end
        end
    end

    // plain software registers
    always_ff @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
            gic_r <= RST_ZERO;
            pien_r <= RST_ZERO;
            dir_r <= RST_DIR;
            sadr_r <= RST_ZERO;
            even_r <= 4'h0;
        end else begin
            if (hit(req, ADDR_GIC, 1'b1)) begin
                gic_r <= req.wdata;
            end
            if (hit(req, ADDR_PIEN, 1'b1)) begin
                pien_r <= req.wdata;
            end
            if (hit(req, ADDR_DIR, 1'b1)) begin
                dir_r <= req.wdata;
            end
            if (hit(req, ADDR_SADR, 1'b1)) begin
                sadr_r <= req.wdata;
            end
            if (hit(req, ADDR_EVEN, 1'b1)) begin
                even_r <= req.wdata[3:0];
            end
        end
    end

    // event flag: set by hardware, cleared only by a software write; set wins
    always_ff @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
            pif_r <= RST_ZERO;
        end else begin
            if (hit(req, ADDR_PIF, 1'b1)) begin
                pif_r <= req.wdata;
            end
            if (|ev_set[2:0]) begin
                pif_r[FLG_EVT] <= 1'b1;
            end
        end
    end

    // sticky per-event status with write-one-to-clear; set wins
    always_ff @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
            evst_r <= 4'h0;
        end else begin
            evst_r <= (evst_r & ~(hit(req, ADDR_EVCLR, 1'b1) ? req.wdata[3:0] : 4'h0))
                      | ev_set;
        end
    end

    always_ff @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
            irq <= 1'b0;
        end else begin
            irq <= (|(evst_r & even_r)) || (pif_r[FLG_EVT] && pien_r[FLG_EVT] &&
                   gic_r[INT_PEIE] && gic_r[INT_GIE]);
        end
    end

    // read data in the cycle after the read strobe; unmapped reads as zero
    always_ff @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
            rd_data <= RST_ZERO;
        end else if (req.rd) begin
            unique case (req.addr)
                ADDR_GIC: rd_data <= gic_r;
                ADDR_PIF: rd_data <= pif_r;
                ADDR_BUF: rd_data <= buf_r;
                ADDR_CON: rd_data <= con_r;
                ADDR_DIR: rd_data <= dir_r;
                ADDR_PIEN: rd_data <= pien_r;
                ADDR_SADR: rd_data <= sadr_r;
                ADDR_STAT: rd_data <= stat_r;
                ADDR_EVST: rd_data <= {4'h0, evst_r};
                ADDR_EVEN: rd_data <= {4'h0, even_r};
                default: rd_data <= RST_ZERO;
            endcase
        end else begin
            rd_data <= RST_ZERO;
        end
    end
endmodule : i2cm_port
`default_nettype wire

// file: verif/i2cm_port_assertions.sv
// concurrent checks on the serial port boundary
`timescale 1ns/1ps
`default_nettype none
module i2cm_port_assertions (
    input wire logic sys_clk,
    input wire logic arst_n,
    input wire i2cm_pkg::i2cm_req_t req,
    input wire logic [7:0] rd_data,
    input wire i2cm_pkg::i2cm_pins_t pin_in,
    input wire i2cm_pkg::i2cm_pins_t pin_out,
    input wire i2cm_pkg::i2cm_pins_t pin_oe,
    input wire logic irq
);
    import i2cm_pkg::*;
    logic en_r;
    logic pie_r;
    logic [3:0] even_r;
    logic dir_wr;
    assign dir_wr = req.wr && (req.addr == ADDR_DIR);
    // shadow of the enables that gate detection and the interrupt
    always_ff @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
            en_r <= 1'b0;
            pie_r <= 1'b0;
            even_r <= 4'h0;
        end else if (req.wr) begin
            if (req.addr == ADDR_CON) en_r <= req.wdata[CON_EN];
            if (req.addr == ADDR_PIEN) pie_r <= req.wdata[FLG_EVT];
            if (req.addr == ADDR_EVEN) even_r <= req.wdata[3:0];
        end
    end
    default clocking @(posedge sys_clk); endclocking
    default disable iff (!arst_n);
    property p_pin_low; pin_out == 2'h0; endproperty
    a_pin_low: assert property (p_pin_low) else $error("pin level not low");
    property p_rd_idle; !$past(req.rd) |-> rd_data == 8'h00; endproperty
    a_rd_idle: assert property (p_rd_idle) else $error("read data outside slot");
    property p_clr_rd; req.rd && req.addr == ADDR_EVCLR |=> rd_data == 8'h00; endproperty
    a_clr_rd: assert property (p_clr_rd) else $error("clear register readable");
    property p_dir_sda;
        req.wr && req.addr == ADDR_DIR |-> ##2 pin_oe.sda == !$past(req.wdata[DIR_SDA], 2);
    endproperty
    a_dir_sda: assert property (p_dir_sda) else $error("data enable wrong");
    property p_hold_cause;
        $rose(pin_oe.scl) |-> !$past(pin_in.scl, 2) || !$past(pin_in.scl, 3)
            || $past(dir_wr, 2);
    endproperty
    a_hold_cause: assert property (p_hold_cause) else $error("hold on high clock");
    // a write reaches the pin enable two edges later, so both past cycles are excused
    property p_hold_stays;
        pin_oe.scl && !req.wr && !$past(req.wr) && !$past(req.wr, 2) |=> pin_oe.scl;
    endproperty
    a_hold_stays: assert property (p_hold_stays) else $error("hold dropped");
    property p_dis_stat;
        req.rd && req.addr == ADDR_STAT && !en_r |=> rd_data[5:0] == 6'h00;
    endproperty
    a_dis_stat: assert property (p_dis_stat) else $error("status while off");
    property p_irq_en; (even_r == 4'h0 && !pie_r) [*3] |-> !irq; endproperty
    a_irq_en: assert property (p_irq_en) else $error("irq while masked");
endmodule : i2cm_port_assertions
bind i2cm_port i2cm_port_assertions i2cm_port_assertions_inst (
    .sys_clk, .arst_n, .req, .rd_data, .pin_in, .pin_out, .pin_oe, .irq);
`default_nettype wire

// file: verif/i2cm_bus_model.sv
// far-side bus master pulling the open-drain lines
`timescale 1ns/1ps
`default_nettype none
module i2cm_bus_model (
    output logic scl_oe,
    output logic sda_oe,
    input wire logic scl,
    input wire logic sda
);
    initial begin
        scl_oe = 1'b0;
        sda_oe = 1'b0;
    end
    task automatic wait_high();
        int n;
        n = 0;
        scl_oe = 1'b0;
        while (!scl && n < 500) begin
            #1;
            n++;
        end
        #32;
    endtask : wait_high
    task automatic gen_start();
        sda_oe = 1'b1;
        #32;
        scl_oe = 1'b1;
        #16;
    endtask : gen_start
    task automatic pull(input logic c, input logic s);
        #1;
        scl_oe = c;
        sda_oe = s;
    endtask : pull
    // ack holds the data line level seen late in the ninth clock high
    task automatic send_byte(input logic [7:0] b, output logic ack);
        for (int i = 7; i >= -1; i--) begin
            sda_oe = (i >= 0) ? !b[i] : 1'b0;
            #16;
            wait_high();
            ack = sda;
            scl_oe = 1'b1;
            #16;
        end
    endtask : send_byte
    task automatic gen_stop();
        sda_oe = 1'b1;
        #16;
        wait_high();
        sda_oe = 1'b0;
        #32;
    endtask : gen_stop
endmodule : i2cm_bus_model
`default_nettype wire

// file: verif/i2cm_port_tb.sv
// self-checking bench for the serial port
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, e) begin checked++; if ((a) !== (e)) begin n_fail++; \
    $display("[ERR] %0t got %h want %h", $time, (a), (e)); end end
module i2cm_port_tb;
    import i2cm_pkg::*;
    logic sys_clk;
    logic arst_n;
    i2cm_req_t req;
    logic [7:0] rd_data;
    i2cm_pins_t pin_in;
    i2cm_pins_t pin_out;
    i2cm_pins_t pin_oe;
    logic irq;
    logic m_scl_oe;
    logic m_sda_oe;
    wire logic scl_w;
    wire logic sda_w;
    int n_fail = 0;
    int checked = 0;
    logic [7:0] d;
    logic ack;
    // pull-ups: a line is low while anyone enables its driver
    assign scl_w = !(m_scl_oe || pin_oe.scl);
    assign sda_w = !(m_sda_oe || pin_oe.sda);
    assign pin_in = {scl_w, sda_w};
    i2cm_port i2cm_port_inst (.sys_clk, .arst_n, .req, .rd_data, .pin_in, .pin_out, .pin_oe, .irq);
    i2cm_bus_model i2cm_bus_model_inst (.scl_oe(m_scl_oe), .sda_oe(m_sda_oe), .scl(scl_w),
        .sda(sda_w));
    initial begin
        sys_clk = 1'b0;
        forever #2.5 sys_clk = ~sys_clk;
    end
    task automatic wr(input logic [7:0] a, input logic [7:0] v);
        @(posedge sys_clk);
        req <= '{addr: a, wdata: v, wr: 1'b1, rd: 1'b0};
        @(posedge sys_clk);
        req.wr <= 1'b0;
    endtask : wr
    task automatic rd(input logic [7:0] a);
        @(posedge sys_clk);
        req <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
        @(posedge sys_clk);
        req.rd <= 1'b0;
        #1;
        d = rd_data;
    endtask : rd
    task automatic t_reset_regs();
        logic [7:0] a[8] = '{ADDR_STAT, ADDR_CON, ADDR_DIR, ADDR_PIEN, ADDR_SADR, ADDR_PIF,
            ADDR_EVCLR, 8'h55};
        for (int i = 0; i < 8; i++) begin
            rd(a[i]);
            `CHK(d, (i == 2) ? 8'hff : 8'h00)
        end
    endtask : t_reset_regs
    task automatic t_dir();
        wr(ADDR_DIR, 8'h3f);
        repeat (3) @(posedge sys_clk);
        `CHK({pin_oe, scl_w, sda_w}, 4'hc)
        wr(ADDR_DIR, 8'h7f);
        repeat (3) @(posedge sys_clk);
        `CHK(pin_oe, 2'b01)
        wr(ADDR_DIR, 8'hbf);
        i2cm_bus_model_inst.pull(1'b0, 1'b1);
        repeat (3) @(posedge sys_clk);
        `CHK(sda_w, 1'b0)
        wr(ADDR_DIR, 8'hff);
        repeat (3) @(posedge sys_clk);
        `CHK({pin_oe, pin_out}, 4'h0)
        `CHK(scl_w, 1'b1)
        i2cm_bus_model_inst.pull(1'b0, 1'b0);
    endtask : t_dir
    task automatic t_frame();
        wr(ADDR_STAT, 8'h00);
        wr(ADDR_CON, 8'h3b);
        wr(ADDR_EVEN, 8'h07);
        rd(ADDR_STAT);
        `CHK(d[4:3], 2'b00)
        i2cm_bus_model_inst.gen_start();
        repeat (8) @(posedge sys_clk);
        `CHK(irq, 1'b1)
        rd(ADDR_STAT);
        `CHK(d[4:3], 2'b01)
        rd(ADDR_EVST);
        `CHK(d, 8'h01)
        wr(ADDR_EVCLR, 8'h0f);
        repeat (2) @(posedge sys_clk);
        `CHK(irq, 1'b0)
        i2cm_bus_model_inst.send_byte(8'ha5, ack);
        repeat (8) @(posedge sys_clk);
        rd(ADDR_EVST);
        `CHK(d, 8'h04)
        rd(ADDR_BUF);
        `CHK(d, 8'ha5)
        wr(ADDR_EVEN, 8'h00);
        wr(ADDR_PIF, 8'h00);
        wr(ADDR_PIEN, 8'h08);
        wr(ADDR_GIC, 8'hc0);
        repeat (2) @(posedge sys_clk);
        `CHK(irq, 1'b0)
        i2cm_bus_model_inst.gen_stop();
        repeat (8) @(posedge sys_clk);
        `CHK(irq, 1'b1)
        rd(ADDR_STAT);
        `CHK(d[4:3], 2'b10)
        wr(ADDR_PIF, 8'h00);
        repeat (2) @(posedge sys_clk);
        `CHK(irq, 1'b0)
        wr(ADDR_PIEN, 8'h00);
        wr(ADDR_CON, 8'h00);
        rd(ADDR_STAT);
        `CHK(d[5:0], 6'h00)
    endtask : t_frame
    task automatic t_hold();
        wr(ADDR_CON, 8'h2b);
        repeat (6) @(posedge sys_clk);
        `CHK(pin_oe.scl, 1'b0)
        i2cm_bus_model_inst.pull(1'b1, 1'b0);
        repeat (6) @(posedge sys_clk);
        i2cm_bus_model_inst.pull(1'b0, 1'b0);
        repeat (6) @(posedge sys_clk);
        `CHK({pin_oe.scl, scl_w}, 2'b10)
        wr(ADDR_CON, 8'h3b);
        repeat (4) @(posedge sys_clk);
        `CHK(scl_w, 1'b1)
    endtask : t_hold
    // slave mode beside master use: address match, ack, overflow, mismatch
    task automatic t_slave();
        wr(ADDR_SADR, 8'h84);
        wr(ADDR_CON, 8'h36);
        i2cm_bus_model_inst.gen_start();
        i2cm_bus_model_inst.send_byte(8'h84, ack);
        `CHK(ack, 1'b0)
        i2cm_bus_model_inst.send_byte(8'h3c, ack);
        `CHK(ack, 1'b0)
        repeat (8) @(posedge sys_clk);
        rd(ADDR_STAT);
        `CHK(d, 8'h29)
        rd(ADDR_BUF);
        `CHK(d, 8'h84)
        rd(ADDR_CON);
        `CHK(d, 8'h76)
        i2cm_bus_model_inst.gen_stop();
        repeat (8) @(posedge sys_clk);
        rd(ADDR_STAT);
        `CHK(d[4:3], 2'b10)
        i2cm_bus_model_inst.gen_start();
        i2cm_bus_model_inst.send_byte(8'h52, ack);
        `CHK(ack, 1'b1)
        i2cm_bus_model_inst.gen_stop();
        wr(ADDR_CON, 8'h00);
    endtask : t_slave
    task automatic final_report();
        $display("checks %0d failures %0d", checked, n_fail);
        if (n_fail == 0 && checked > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask : final_report
    initial begin
        #100000;
        n_fail++;
        final_report();
    end
    initial begin
        req = '0;
        arst_n = 1'b0;
        repeat (8) @(posedge sys_clk);
        arst_n <= 1'b1;
        t_reset_regs();
        t_dir();
        t_frame();
        t_hold();
        t_slave();
        final_report();
    end
endmodule : i2cm_port_tb
`undef CHK
`default_nettype wire
